// ==== shared/fsf_pkg.sv ====
package fsf_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CFG2 = 8'hFB;
  localparam logic [7:0] ADDR_THR = 8'hFC;
  localparam logic [7:0] ADDR_LVL_HI = 8'hFD;
  localparam logic [7:0] ADDR_STAT0 = 8'hFE;
  localparam logic [7:0] ADDR_DATA = 8'hFF;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int LIGHT_EN_BIT = 7;
  localparam int COMP_EN_BIT = 5;
  localparam int DELTA_EN_BIT = 4;
  localparam int OVF_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam logic [7:0] CFG2_RESET = 8'h8F;
  localparam logic [7:0] THR_RESET = 8'h7F;
  localparam int DEPTH = 512;
  localparam int AW = 9;
  localparam int LW = 10;
  localparam int SW = 16;
  // Incoming sample with its kind
  typedef struct packed {
    logic valid;
    logic is_light;
    logic [SW-1:0] value;
  } fsf_sample_t;
  // Register access strobe from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsf_reg_req_t;
endpackage : fsf_pkg

// ==== rtl/fsf_flicker_sample_fifo.sv ====
// Overview of operation
// - Compression enable compresses modulator 2 flicker samples before storing.
// - Difference enable stores change from previous sample; meaningful with compression.
// - Four-bit width field n, reset 15, stores sample bits 0 to n.
// - Threshold irq high while fill count exceeds threshold bits 8:1.
// - 512 byte entries, ten-bit fill count split 9:2 and 1:0.
// - Overflow flag sets on lost write, held until power-on or clear.
// - Underflow flag sets on over-read, cleared by power-on or clear.
// - Each data read of a non-empty FIFO, unless a clear comes in the same cycle, advances read pointer and, unless a byte is also written, decrements fill count.
// - Reading an empty FIFO returns zero and sets underflow.
// - Light store enable writes light data when flicker sampling ends.
`timescale 1ns/100ps
module fsf_flicker_sample_fifo
  import fsf_pkg::*;
(
  input wire logic sys_clk, // 20 MHz system clock
  input wire logic sys_rst, // Sync reset, power-on
  input wire fsf_reg_req_t reg_req, // Register access strobes
  output logic [7:0] reg_rdata, // Read data, registered
  input wire fsf_sample_t sample_in, // Modulator 2 sample
  input wire logic flicker_active, // Flicker sampling running
  input wire logic fifo_clear_cmd, // Pulse, empties FIFO
  output logic sample_ready, // Packer can take a sample
  output logic fill_threshold_irq // Level above threshold
);
  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] cfg2;
  logic [7:0] thr;
  logic m2_light_store_en;
  logic m2_flicker_compress_en;
  logic m2_delta_store_en;
  logic [3:0] m2_sample_bit_count;
  assign m2_light_store_en = cfg2[LIGHT_EN_BIT];
  assign m2_flicker_compress_en = cfg2[COMP_EN_BIT];
  assign m2_delta_store_en = cfg2[DELTA_EN_BIT];
  assign m2_sample_bit_count = cfg2[3:0];

  // Host writes to the two writable registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg2 <= CFG2_RESET;
      thr <= THR_RESET;
    end else if (reg_req.wr) begin
      if (reg_req.addr == ADDR_CFG2) begin
        cfg2 <= reg_req.wdata & 8'hBF; // Bit 6 reserved
      end
      if (reg_req.addr == ADDR_THR) begin
        thr <= reg_req.wdata;
      end
    end
  end

  // ****************************************
  // Sample shaping
  // ****************************************
  logic [SW-1:0] prev_sample;
  logic [SW-1:0] trunc_val;
  logic [SW-1:0] delta_val;
  logic [SW-1:0] shaped_val;
  logic [1:0] shaped_bytes;
  logic accept;
  logic [4:0] nbits;

  // Compression: drop leading zero bytes of the value
  function automatic logic [1:0] fsf_byte_need(input logic [SW-1:0] v);
    fsf_byte_need = (v[SW-1:8] != 8'h00) ? 2'h2 : 2'h1;
  endfunction : fsf_byte_need

  // Light data only once flicker sampling is off or finished
  // light store gate
  assign accept = sample_in.valid & sample_ready &
                  (sample_in.is_light ? (m2_light_store_en & ~flicker_active)
                                      : 1'b1);

  always_comb begin
    nbits = 5'(m2_sample_bit_count) + 5'h01;
    trunc_val = sample_in.value & SW'((32'h1 << nbits) - 32'h1);
    delta_val = trunc_val - prev_sample;
    shaped_val = (m2_delta_store_en & m2_flicker_compress_en &
                  ~sample_in.is_light) ? delta_val : trunc_val;
    if (m2_flicker_compress_en & ~sample_in.is_light) begin
      shaped_bytes = fsf_byte_need(shaped_val);
    end else begin
      shaped_bytes = (nbits > 5'h08) ? 2'h2 : 2'h1;
    end
  end

  // Previous flicker sample, kept for the difference mode
  always_ff @(posedge sys_clk) begin
    if (sys_rst | fifo_clear_cmd) begin
      prev_sample <= '0;
    end else if (accept & ~sample_in.is_light) begin
      prev_sample <= trunc_val;
    end
  end

  // ****************************************
  // Byte packer
  // ****************************************
  logic [SW-1:0] pack_val;
  logic [1:0] pack_left;
  logic wr_en;
  logic [7:0] wr_byte;

  // One byte per cycle; a new sample waits until the last byte goes
  assign sample_ready = (pack_left == 2'h0);
  assign wr_en = (pack_left != 2'h0);
  assign wr_byte = pack_val[7:0];

  always_ff @(posedge sys_clk) begin
    if (sys_rst | fifo_clear_cmd) begin
      pack_val <= '0;
      pack_left <= 2'h0;
    end else if (accept) begin
      pack_val <= shaped_val;
      pack_left <= shaped_bytes;
    end else if (wr_en) begin
      pack_val <= pack_val >> 8;
      pack_left <= pack_left - 2'h1;
    end
  end

  // ****************************************
  // Storage and pointers
  // ****************************************
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [LW-1:0] fill_count;
  logic fifo_full;
  logic fifo_empty;
  logic rd_data_strobe;
  logic do_write;
  logic do_read;
  logic ovf_flag;
  logic unf_flag;

  assign fifo_full = (fill_count == LW'(DEPTH));
  assign fifo_empty = (fill_count == '0);
  assign rd_data_strobe = reg_req.rd & (reg_req.addr == ADDR_DATA);
  assign do_write = wr_en & ~fifo_full;
  assign do_read = rd_data_strobe & ~fifo_empty;

  // Byte array, written only when space remains
  always_ff @(posedge sys_clk) begin
    if (do_write) begin
      mem[wr_ptr] <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst | fifo_clear_cmd) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill_count <= '0;
    end else begin
      if (do_write) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (do_read) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      fill_count <= fill_count + LW'(do_write) - LW'(do_read);
    end
  end

  // Sticky flags; clear loses to a same-cycle event
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ovf_flag <= 1'b0;
      unf_flag <= 1'b0;
    end else begin
      if (wr_en & fifo_full) begin
        ovf_flag <= 1'b1;
      end else if (fifo_clear_cmd) begin
        ovf_flag <= 1'b0;
      end
      if (rd_data_strobe & fifo_empty) begin
        unf_flag <= 1'b1;
      end else if (fifo_clear_cmd) begin
        unf_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read data and interrupt
  // ****************************************
  // Read mux, registered so data stands after the strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_CFG2: reg_rdata <= cfg2;
        ADDR_THR: reg_rdata <= thr;
        ADDR_LVL_HI: reg_rdata <= fill_count[9:2];
        ADDR_STAT0: reg_rdata <= {ovf_flag, unf_flag, 4'h0,
                                  fill_count[1:0]};
        ADDR_DATA: reg_rdata <= fifo_empty ? 8'h00 : mem[rd_ptr];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fill_threshold_irq <= 1'b0;
    end else begin
      fill_threshold_irq <= (fill_count > {1'b0, thr, 1'b0});
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // irq tracks level
  irq_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 fill_threshold_irq == ($past(fill_count) > {1'b0, $past(thr), 1'b0}))
    else $error("threshold irq wrong");
  count_bound_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst) fill_count <= LW'(DEPTH))
    else $error("fill count above depth");
  ovf_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ovf_flag & ~fifo_clear_cmd |=> ovf_flag) else $error("overflow lost");
  ovf_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_en & fifo_full |=> ovf_flag &
    (fill_count == LW'(DEPTH) | $past(do_read) | $past(fifo_clear_cmd)))
    else $error("overflow not set");
  unf_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_data_strobe & fifo_empty |=> unf_flag) else $error("underflow not set");
  empty_zero_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    rd_data_strobe & fifo_empty |=> reg_rdata == 8'h00)
    else $error("empty read not zero");
  read_dec_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    do_read & ~do_write & ~fifo_clear_cmd |=>
    fill_count == $past(fill_count) - 1'b1) else $error("count not decreased");
  clear_empty_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    fifo_clear_cmd |=> fifo_empty & wr_ptr == rd_ptr)
    else $error("clear left data");
  pack_drain_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    accept & ~fifo_clear_cmd |=> ##[0:2] sample_ready)
    else $error("packer stuck");
  light_gate_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sample_in.valid & sample_in.is_light & flicker_active |-> ~accept)
    else $error("light stored during flicker");
  trunc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    m2_sample_bit_count == 4'h7 |-> trunc_val[SW-1:8] == 8'h00)
    else $error("truncation wrong");
  write_inc_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst) do_write & ~do_read & ~fifo_clear_cmd |=>
    fill_count == $past(fill_count) + LW'(1))
    else $error("count not raised");
  unf_sticky_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst) unf_flag & ~fifo_clear_cmd |=> unf_flag)
    else $error("underflow lost");
  flag_clear_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    fifo_clear_cmd & ~(wr_en & fifo_full) & ~(rd_data_strobe & fifo_empty)
    |=> ~ovf_flag & ~unf_flag) else $error("clear kept a flag");
  comp_size_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst) accept & m2_flicker_compress_en &
    ~sample_in.is_light & shaped_val[SW-1:8] == 8'h00 |->
    shaped_bytes == 2'h1) else $error("compression kept a zero byte");
  delta_store_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst) accept & m2_delta_store_en &
    m2_flicker_compress_en & ~sample_in.is_light & ~fifo_clear_cmd |=>
    pack_val == $past(trunc_val) - $past(prev_sample))
    else $error("delta not stored");
  low_first_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst) accept & ~fifo_clear_cmd |=>
    wr_en & {8'h00, wr_byte} == ($past(shaped_val) & 16'h00FF))
    else $error("low byte not first");
  count_ptr_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst) fill_count[AW-1:0] == AW'(wr_ptr - rd_ptr))
    else $error("count and pointers disagree");
endmodule : fsf_flicker_sample_fifo

// ==== verif/fsf_host_model.sv ====
`timescale 1ns/100ps
// ****************************************
// Host side of the register port
// ****************************************
module fsf_host_model
  import fsf_pkg::*;
(
  input wire logic sys_clk, // System clock
  output fsf_reg_req_t reg_req, // Strobes to device
  input wire logic [7:0] reg_rdata // Device answer
);
  initial reg_req = '0;
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) reg_req <= '0;
  endtask : wr
  // Data lands one edge after the strobe is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) reg_req <= '0;
    @(posedge sys_clk) d = reg_rdata;
  endtask : rd
  // Level then flags, never split apart
  task automatic status(output logic [9:0] lvl, output logic [1:0] fl);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(ADDR_LVL_HI, hi);
    rd(ADDR_STAT0, lo);
    lvl = {hi, lo[1:0]};
    fl = lo[7:6];
  endtask : status
endmodule : fsf_host_model

// ==== verif/fsf_flicker_sample_fifo_tb_top.sv ====
`timescale 1ns/100ps
// ****************************************
// Sample FIFO bench
// ****************************************
module fsf_flicker_sample_fifo_tb_top import fsf_pkg::*;;
  logic sys_clk, sys_rst, flicker_active, fifo_clear_cmd;
  logic sample_ready, fill_threshold_irq;
  logic [7:0] reg_rdata;
  fsf_reg_req_t reg_req;
  fsf_sample_t sample_in;
  int err_total = 0;
  int cmp_count = 0;
  logic push_busy;
  fsf_flicker_sample_fifo uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .sample_in(sample_in),
    .flicker_active(flicker_active), .fifo_clear_cmd(fifo_clear_cmd),
    .sample_ready(sample_ready), .fill_threshold_irq(fill_threshold_irq));
  fsf_host_model h (.sys_clk(sys_clk), .reg_req(reg_req),
    .reg_rdata(reg_rdata));
  // 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    h.rd(a, d);
    chk(d, e);
  endtask : rdc
  task automatic stc(input logic [9:0] el, input logic [1:0] ef);
    logic [9:0] l;
    logic [1:0] f;
    h.status(l, f);
    chk(l, el);
    chk(f, ef);
  endtask : stc
  // Offer one sample; packer done within three edges
  // Busy seen one edge after the take, dropped samples leave it idle
  task automatic push(input logic lt, input logic [15:0] v);
    @(posedge sys_clk) sample_in <= '{1'b1, lt, v};
    @(posedge sys_clk) sample_in.valid <= 1'b0;
    @(posedge sys_clk) push_busy = ~sample_ready;
    repeat (2) @(posedge sys_clk);
  endtask : push
  task automatic clr;
    @(posedge sys_clk) fifo_clear_cmd <= 1'b1;
    @(posedge sys_clk) fifo_clear_cmd <= 1'b0;
  endtask : clr
  // Reset values, read-only and unmapped places
  task automatic t_regs;
    rdc(ADDR_CFG2, 8'h8F);
    rdc(ADDR_THR, 8'h7F);
    h.wr(ADDR_LVL_HI, 8'h55);
    stc(10'h000, 2'b00);
    rdc(8'h10, 8'h00);
  endtask : t_regs
  // Empty read, then clear
  task automatic t_under;
    rdc(ADDR_DATA, 8'h00);
    stc(10'h000, 2'b01);
    clr();
    stc(10'h000, 2'b00);
  endtask : t_under
  // Width and byte order
  task automatic t_width;
    h.wr(ADDR_CFG2, 8'h07);
    push(1'b0, 16'h1234);
    stc(10'h001, 2'b00);
    rdc(ADDR_DATA, 8'h34);
    h.wr(ADDR_CFG2, 8'h0F);
    push(1'b0, 16'hABCD);
    chk(push_busy, 1'b1);
    chk(sample_ready, 1'b1);
    stc(10'h002, 2'b00);
    rdc(ADDR_DATA, 8'hCD);
    rdc(ADDR_DATA, 8'hAB);
    stc(10'h000, 2'b00);
  endtask : t_width
  // Compression and difference
  task automatic t_comp;
    h.wr(ADDR_CFG2, 8'h2F);
    push(1'b0, 16'h0012);
    stc(10'h001, 2'b00);
    rdc(ADDR_DATA, 8'h12);
    h.wr(ADDR_CFG2, 8'h3F);
    push(1'b0, 16'h0100);
    rdc(ADDR_DATA, 8'hEE);
    push(1'b0, 16'h0105);
    stc(10'h001, 2'b00);
    rdc(ADDR_DATA, 8'h05);
  endtask : t_comp
  // Light samples dropped during flicker or with store off
  task automatic t_light;
    h.wr(ADDR_CFG2, 8'h8F);
    flicker_active <= 1'b1;
    push(1'b1, 16'h55AA);
    chk(push_busy, 1'b0);
    stc(10'h000, 2'b00);
    flicker_active <= 1'b0;
    push(1'b1, 16'h55AA);
    stc(10'h002, 2'b00);
    rdc(ADDR_DATA, 8'hAA);
    clr();
    h.wr(ADDR_CFG2, 8'h0F);
    push(1'b1, 16'h55AA);
    stc(10'h000, 2'b00);
  endtask : t_light
  // Threshold compare, strict greater-than
  task automatic t_irq;
    h.wr(ADDR_THR, 8'h00);
    h.wr(ADDR_CFG2, 8'h07);
    push(1'b0, 16'h0001);
    chk(fill_threshold_irq, 1'b1);
    rdc(ADDR_DATA, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk(fill_threshold_irq, 1'b0);
    h.wr(ADDR_THR, 8'h01);
    h.wr(ADDR_CFG2, 8'h0F);
    push(1'b0, 16'h0203);
    chk(fill_threshold_irq, 1'b0);
    push(1'b0, 16'h0203);
    chk(fill_threshold_irq, 1'b1);
    clr();
    h.wr(ADDR_THR, 8'h7F);
  endtask : t_irq
  // Fill to 512, lose a sample, sticky flag
  task automatic t_full;
    repeat (256) push(1'b0, 16'h1234);
    stc(10'h200, 2'b00);
    push(1'b0, 16'h5678);
    stc(10'h200, 2'b10);
    rdc(ADDR_DATA, 8'h34);
    stc(10'h1FF, 2'b10);
    clr();
    stc(10'h000, 2'b00);
  endtask : t_full
  initial begin
    sys_rst = 1'b1;
    sample_in = '0;
    flicker_active = 1'b0;
    fifo_clear_cmd = 1'b0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_under();
    t_width();
    t_comp();
    t_light();
    t_irq();
    t_full();
    end_of_test();
  end
  // Whole run needs about 1500 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end
endmodule : fsf_flicker_sample_fifo_tb_top
